// ===== logic/tmrc_defs.svh
// register map, field positions and reset values of the timer compare block
`ifndef TMRC_DEFS_SVH
`define TMRC_DEFS_SVH

`define TMRC_ADDR_STAGE 3'h0
`define TMRC_ADDR_COUNT 3'h1
`define TMRC_ADDR_CMP_A 3'h2
`define TMRC_ADDR_CMP_B 3'h3
`define TMRC_ADDR_PERIOD 3'h4
`define TMRC_ADDR_CTRL 3'h5
`define TMRC_ADDR_FLAGS 3'h6

`define TMRC_CTRL_MODE_HI 7
`define TMRC_CTRL_MODE_LO 6
`define TMRC_CTRL_REV 0

`define TMRC_STAGE_RST 2'h0
`define TMRC_COUNT_RST 10'h000
`define TMRC_CMP_RST 10'h000
`define TMRC_PERIOD_RST 10'h3ff
`define TMRC_PERIOD_MIN 10'h003

`endif

// ===== logic/tmrc_pkg.sv
// types shared by the timer compare block
package tmrc_pkg;

	typedef logic [9:0] tmrc_word_t;

	typedef enum logic [1:0]
	{
		TMRC_WAVE_NONE,
		TMRC_WAVE_TOGGLE,
		TMRC_WAVE_CLEAR,
		TMRC_WAVE_SET
	} tmrc_wave_e;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} tmrc_req_s;

endpackage

// ===== logic/tmrc_match.sv
// one compare channel: match detect and delayed sticky flag
`timescale 1ns/100ps
module tmrc_match
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic step,
	input wire tmrc_pkg::tmrc_word_t next_count,
	input wire tmrc_pkg::tmrc_word_t value,
	input wire logic clr,
	output logic match,
	output logic flag
);
	import tmrc_pkg::*;

	logic match_d;

	// only a counting step can land on the value, never a write
	assign match = step && (next_count == value);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			match_d <= 1'b0;
		else
			match_d <= match;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			flag <= 1'b0;
		else if (match_d)
			flag <= 1'b1;
		else if (clr)
			flag <= 1'b0;
	end
endmodule

// ===== logic/tmrc_top.sv
// 10-bit timer counter with staged 8-bit access and three compare registers
//
// Notes on behaviour
// R1: stage register bits 7 to 2 always read as zero.
// R2: stage bits 1:0 carry the top two bits of every 10-bit access.
// R3: one stage register serves all 10-bit registers of the timer.
// R4: compare A and B match only when the counter steps onto them.
// R5: software writing counter or compare to equal values gives no match.
// R6: compare A match sets its flag after a synchronising delay.
// R7: compare B match sets its flag after a synchronising delay.
// R8: counter reaching the period compare value while counting up is cleared to zero.
// R9: period compare clears the counter only when counting up; counting down reloads the period value at zero.
// R10: period compare writes below three store three instead.
// R11: compare registers are 10 bits, reached by staged 8-bit access.
// R12: all three compare registers are readable and writable by software.
// R13: compare A output action follows the mode in control register A.
// R14: counter is 10 bits, counts up or down, software reads and writes it.
// R15: after a counter write the counter counts upward.
// R16: stage written first, low byte commits; low-byte read loads the stage.
`timescale 1ns/100ps
`include "tmrc_defs.svh"
module tmrc_top
(
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire tmrc_pkg::tmrc_req_s BUS_REQ,
	input wire logic COUNT_TICK,
	output logic [7:0] RDATA,
	output tmrc_pkg::tmrc_word_t TIMER_COUNT,
	output logic COMPARE_A_FLAG,
	output logic COMPARE_B_FLAG,
	output logic PERIOD_MATCH,
	output logic WAVE_A
);
	import tmrc_pkg::*;

	logic [1:0] stage;
	tmrc_word_t count;
	tmrc_word_t period;
	tmrc_word_t next_step_count;
	tmrc_word_t cmp [2];
	tmrc_word_t wval;
	logic [1:0] match;
	logic [1:0] flag;
	logic [1:0] flag_clr;
	logic dir_down;
	tmrc_wave_e wave_mode;
	logic count_write;
	logic step;
	logic c_match;

	assign wval = {stage, BUS_REQ.wdata};
	assign count_write = BUS_REQ.wr && BUS_REQ.addr == `TMRC_ADDR_COUNT;
	assign step = COUNT_TICK && !count_write;
	assign c_match = step && !dir_down && count == period; // R8 R9

	always_comb
	begin
		if (dir_down)
			next_step_count = (count == 10'h000) ? period : count - 10'h001;
		else if (count == period)
			next_step_count = 10'h000; // R8
		else
			next_step_count = count + 10'h001; // R14
	end

	// counter
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			count <= `TMRC_COUNT_RST;
		else if (count_write)
			count <= wval; // R14 R16
		else if (step)
			count <= next_step_count;
	end

	// direction: reverse on command, upward after every counter write
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			dir_down <= 1'b0;
		else if (count_write)
			dir_down <= 1'b0; // R15
		else if (BUS_REQ.wr && BUS_REQ.addr == `TMRC_ADDR_CTRL &&
			BUS_REQ.wdata[`TMRC_CTRL_REV])
			dir_down <= 1'b1;
	end

	// shared stage register
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			stage <= `TMRC_STAGE_RST;
		else if (BUS_REQ.wr && BUS_REQ.addr == `TMRC_ADDR_STAGE)
			stage <= BUS_REQ.wdata[1:0]; // R2 R3
		else if (BUS_REQ.rd)
		begin
			unique case (BUS_REQ.addr)
				`TMRC_ADDR_COUNT: stage <= count[9:8]; // R16
				`TMRC_ADDR_CMP_A: stage <= cmp[0][9:8]; // R16
				`TMRC_ADDR_CMP_B: stage <= cmp[1][9:8]; // R16
				`TMRC_ADDR_PERIOD: stage <= period[9:8]; // R16
				default: stage <= stage;
			endcase
		end
	end

	// period compare with minimum clamp
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			period <= `TMRC_PERIOD_RST;
		else if (BUS_REQ.wr && BUS_REQ.addr == `TMRC_ADDR_PERIOD)
			period <= (wval < `TMRC_PERIOD_MIN) ? `TMRC_PERIOD_MIN : wval; // R10
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			wave_mode <= TMRC_WAVE_NONE;
		else if (BUS_REQ.wr && BUS_REQ.addr == `TMRC_ADDR_CTRL)
			wave_mode <= tmrc_wave_e'(BUS_REQ.wdata[
				`TMRC_CTRL_MODE_HI:`TMRC_CTRL_MODE_LO]);
	end

	// compare channels A and B
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_cmp
			always_ff @(posedge CORE_CLK)
			begin
				if (!RESET_N)
					cmp[i] <= `TMRC_CMP_RST;
				else if (BUS_REQ.wr &&
					BUS_REQ.addr == `TMRC_ADDR_CMP_A + 3'(i))
					cmp[i] <= wval; // R11 R12
			end

			assign flag_clr[i] = BUS_REQ.wr &&
				BUS_REQ.addr == `TMRC_ADDR_FLAGS && BUS_REQ.wdata[i];

			tmrc_match u_match
			(
				.clk(CORE_CLK),
				.rst_n(RESET_N),
				.step(step), // R4 R5
				.next_count(next_step_count),
				.value(cmp[i]),
				.clr(flag_clr[i]),
				.match(match[i]),
				.flag(flag[i]) // R6 R7
			);
		end
	endgenerate

	// compare A output action
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			WAVE_A <= 1'b0;
		else if (match[0])
		begin
			unique case (wave_mode)
				TMRC_WAVE_NONE: WAVE_A <= WAVE_A; // R13
				TMRC_WAVE_TOGGLE: WAVE_A <= !WAVE_A; // R13
				TMRC_WAVE_CLEAR: WAVE_A <= 1'b0; // R13
				TMRC_WAVE_SET: WAVE_A <= 1'b1; // R13
			endcase
		end
	end

	// read data register
	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			RDATA <= 8'h00;
		else if (BUS_REQ.rd)
		begin
			unique case (BUS_REQ.addr)
				`TMRC_ADDR_STAGE: RDATA <= {6'h00, stage}; // R1
				`TMRC_ADDR_COUNT: RDATA <= count[7:0];
				`TMRC_ADDR_CMP_A: RDATA <= cmp[0][7:0]; // R12
				`TMRC_ADDR_CMP_B: RDATA <= cmp[1][7:0]; // R12
				`TMRC_ADDR_PERIOD: RDATA <= period[7:0]; // R12
				`TMRC_ADDR_CTRL: RDATA <= {wave_mode, 6'h00};
				`TMRC_ADDR_FLAGS: RDATA <= {6'h00, flag};
				default: RDATA <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
			PERIOD_MATCH <= 1'b0;
		else
			PERIOD_MATCH <= c_match;
	end

	assign TIMER_COUNT = count;
	assign COMPARE_A_FLAG = flag[0];
	assign COMPARE_B_FLAG = flag[1];

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	property p_stage_read_zero;
		BUS_REQ.rd && BUS_REQ.addr == `TMRC_ADDR_STAGE |=> RDATA[7:2] == 6'h00;
	endproperty
	a_stage_read_zero: assert property (p_stage_read_zero) // R1
		else $error("stage reserved bits not zero");

	property p_staged_write;
		BUS_REQ.wr && BUS_REQ.addr == `TMRC_ADDR_CMP_A
			|=> cmp[0] == {$past(stage), $past(BUS_REQ.wdata)};
	endproperty
	a_staged_write: assert property (p_staged_write) // R2
		else $error("compare A not written from stage and low byte");

	property p_read_loads_stage;
		BUS_REQ.rd && BUS_REQ.addr == `TMRC_ADDR_CMP_B
			|=> stage == $past(cmp[1][9:8]);
	endproperty
	a_read_loads_stage: assert property (p_read_loads_stage) // R16
		else $error("low byte read did not load stage");

	property p_match_on_step;
		match[0] |-> step && count != cmp[0];
	endproperty
	a_match_on_step: assert property (p_match_on_step) // R4
		else $error("compare A match without a counting step");

	property p_no_match_on_write;
		count_write |-> match == 2'b00;
	endproperty
	a_no_match_on_write: assert property (p_no_match_on_write) // R5
		else $error("compare match from a counter write");

	property p_flag_a_delay;
		match[0] |-> ##2 COMPARE_A_FLAG;
	endproperty
	a_flag_a_delay: assert property (p_flag_a_delay) // R6
		else $error("compare A flag not set two cycles after match");

	property p_flag_b_delay;
		match[1] |-> ##2 COMPARE_B_FLAG;
	endproperty
	a_flag_b_delay: assert property (p_flag_b_delay) // R7
		else $error("compare B flag not set two cycles after match");

	property p_period_clear;
		c_match |=> count == 10'h000 && PERIOD_MATCH;
	endproperty
	a_period_clear: assert property (p_period_clear) // R8
		else $error("period match did not clear the counter");

	property p_period_clamp;
		BUS_REQ.wr && BUS_REQ.addr == `TMRC_ADDR_PERIOD && wval < 10'h003
			|=> period == 10'h003;
	endproperty
	a_period_clamp: assert property (p_period_clamp) // R10
		else $error("period below three not clamped");

	property p_count_up_after_write;
		count_write ##1 COUNT_TICK && !count_write && count != period
			|=> count == $past(count) + 10'h001;
	endproperty
	a_count_up_after_write: assert property (p_count_up_after_write) // R15
		else $error("counter not counting up after write");

	property p_wave_set;
		match[0] && wave_mode == TMRC_WAVE_SET |=> WAVE_A;
	endproperty
	a_wave_set: assert property (p_wave_set) // R13
		else $error("compare A set action missing");
endmodule

// ===== test/tmrc_cpu.sv
// cpu model issuing staged 10-bit register accesses on the 8-bit bus
`timescale 1ns/100ps
module tmrc_cpu
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	output tmrc_pkg::tmrc_req_s req
);
	import tmrc_pkg::*;
	initial req = '0;
	// one access: driven after an edge, taken at the next, then released
	task automatic acc(input logic w, input logic [2:0] a,
		input logic [7:0] d);
		@(posedge clk);
		#1;
		req = '{w, !w, a, d};
		@(posedge clk);
		#1;
		req = '{1'b0, 1'b0, a, ~d};
	endtask
	task automatic wr10(input logic [2:0] a, input logic [9:0] v);
		acc(1'b1, 3'h0, {6'h00, v[9:8]});
		acc(1'b1, a, v[7:0]);
	endtask
	// returns {stage byte, low byte}
	task automatic rd10(input logic [2:0] a, output logic [15:0] v);
		acc(1'b0, a, 8'h00);
		v[7:0] = rdata;
		acc(1'b0, 3'h0, 8'h00);
		v[15:8] = rdata;
	endtask
endmodule

// ===== test/tb_timer_ten_bit_compare_access.sv
// self-checking bench of the timer compare block
`timescale 1ns/100ps
`include "tmrc_defs.svh"
module tb_timer_ten_bit_compare_access;
	import tmrc_pkg::*;
	logic clk;
	logic rst_n;
	logic tick;
	tmrc_req_s req;
	logic [7:0] rdata;
	tmrc_word_t cnt;
	logic fa;
	logic fb;
	logic pm;
	logic wave;
	int num_errors;
	int comparisons;
	int i;
	logic [9:0] w;
	logic [15:0] v;
	logic [2:0] a;
	tmrc_top i_dut
	(
		.CORE_CLK(clk),
		.RESET_N(rst_n),
		.BUS_REQ(req),
		.COUNT_TICK(tick),
		.RDATA(rdata),
		.TIMER_COUNT(cnt),
		.COMPARE_A_FLAG(fa),
		.COMPARE_B_FLAG(fb),
		.PERIOD_MATCH(pm),
		.WAVE_A(wave)
	);
	tmrc_cpu i_cpu
	(
		.clk(clk),
		.rdata(rdata),
		.req(req)
	);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [15:0] exp_rd(input logic [2:0] a,
		input logic [9:0] v);
		if (a == `TMRC_ADDR_PERIOD && v < 10'h003)
			v = `TMRC_PERIOD_MIN;
		return {6'h00, v};
	endfunction
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] s);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic step(input int n);
		@(posedge clk);
		#1;
		tick = 1'b1;
		repeat (n) @(posedge clk);
		#1;
		tick = 1'b0;
	endtask
	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#40000;
		num_errors++;
		finish_test();
	end
	initial
	begin
		void'($urandom(19239));
		tick = 1'b0;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		i_cpu.rd10(`TMRC_ADDR_PERIOD, v);
		chk("period_reset", 16'h03ff, v);
		i_cpu.acc(1'b1, `TMRC_ADDR_STAGE, 8'hff);
		i_cpu.acc(1'b0, `TMRC_ADDR_STAGE, 8'h00);
		chk("stage", 16'h0003, {8'h00, rdata});
		for (i = 0; i < 16; i++)
		begin
			a = (i < 4) ? `TMRC_ADDR_PERIOD : 3'(1 + i % 4);
			w = (i < 4) ? 10'(i) : 10'($urandom);
			i_cpu.wr10(a, w);
			i_cpu.rd10(a, v);
			chk("reg_rw", exp_rd(a, w), v);
		end
		for (i = 2; i < 4; i++)
		begin
			i_cpu.acc(1'b1, `TMRC_ADDR_FLAGS, 8'h03);
			i_cpu.acc(1'b1, `TMRC_ADDR_CTRL, 8'hc0);
			i_cpu.wr10(`TMRC_ADDR_PERIOD, 10'h3ff);
			w = 10'($urandom_range(1000, 5));
			i_cpu.wr10(3'(i), w);
			i_cpu.wr10(`TMRC_ADDR_COUNT, w);
			repeat (4) @(posedge clk);
			#1;
			chk("no_match", 0, (i == 2) ? fa : fb);
			i_cpu.wr10(`TMRC_ADDR_COUNT, w - 10'h001);
			step(1);
			chk("count", w, cnt);
			chk("flag_early", 0, (i == 2) ? fa : fb);
			if (i == 2)
				chk("wave", 1, wave);
			@(posedge clk);
			#1;
			chk("flag", 1, (i == 2) ? fa : fb);
			i_cpu.acc(1'b0, `TMRC_ADDR_FLAGS, 8'h00);
			chk("flag_reg", 1, rdata[i - 2]);
		end
		w = 10'($urandom_range(200, 20));
		i_cpu.wr10(`TMRC_ADDR_PERIOD, w);
		i_cpu.wr10(`TMRC_ADDR_COUNT, w - 10'h001);
		step(2);
		chk("count_clear", 0, cnt);
		chk("period_pulse", 1, pm);
		@(posedge clk);
		#1;
		chk("period_pulse_end", 0, pm);
		i_cpu.acc(1'b1, `TMRC_ADDR_CTRL, 8'h01);
		step(1);
		chk("count_down", w, cnt);
		i_cpu.wr10(`TMRC_ADDR_COUNT, 10'h00a);
		step(1);
		chk("count_up", 16'h000b, cnt);
		finish_test();
	end
endmodule
